// ==== hw/dmdc_regs.vh ====
/*
 Constants for the dual modulus divider control block.
 Assumes inclusion by bare name from the design files under hw/.
*/
`ifndef DMDC_REGS_VH
`define DMDC_REGS_VH

// Digit width of one decimal counter stage
`define DMDC_DIGIT_W      4
// Main counter decades and swallow counter decades
`define DMDC_MAIN_DIGITS  2
`define DMDC_SWAL_DIGITS  2
// Binary width of the main counter value (0..99)
`define DMDC_CNT_W        8
// Decimal radix of one decade
`define DMDC_RADIX        4'hA
// Main count value at which early decode is armed
`define DMDC_EARLY_VALUE  8'h02
// Modulus select encoding: high requests the lower modulus
`define DMDC_SEL_LOWER    1'b1
`define DMDC_SEL_UPPER    1'b0

`endif

// ==== hw/dmdc_bcd_stage.v ====
/*
 Two-decade loadable BCD down-counter with hold and zero detect.
 Assumes digit inputs are valid BCD and the clock is the prescaler output.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dmdc_regs.vh"

module dmdc_bcd_stage (
    // Clock and control
    input  wire                     clock,
    input  wire                     load,
    input  wire                     dec,
    // Programmed value
    input  wire [`DMDC_DIGIT_W-1:0] loadHigh,
    input  wire [`DMDC_DIGIT_W-1:0] loadLow,
    // Count state
    output wire [`DMDC_DIGIT_W-1:0] countHigh,
    output wire [`DMDC_DIGIT_W-1:0] countLow,
    output wire                     isZero
);

    reg [`DMDC_DIGIT_W-1:0] high_reg;
    reg [`DMDC_DIGIT_W-1:0] low_reg;

    // Load wins over decrement; low digit borrows from high digit
    always @(posedge clock) begin
        if (load) begin
            high_reg <= loadHigh;
            low_reg  <= loadLow;
        end else if (dec && !isZero) begin
            if (low_reg == 4'h0) begin
                low_reg  <= `DMDC_RADIX - 4'h1;
                high_reg <= high_reg - 4'h1;
            end else begin
                low_reg <= low_reg - 4'h1;
            end
        end
    end

    assign countHigh = high_reg;
    assign countLow  = low_reg;
    assign isZero    = (high_reg == 4'h0) && (low_reg == 4'h0);

endmodule // dmdc_bcd_stage
`default_nettype wire

// ==== hw/dmdc_sel_latch.v ====
/*
 Modulus select latch: set by swallow zero detect, cleared by a pulse.
 Assumes set and clear are never both meant to win; set wins.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dmdc_regs.vh"

module dmdc_sel_latch (
    // Clock and reset
    input  wire clock,
    input  wire srst,
    // Control
    input  wire setLower,
    input  wire clearPulse,
    // State
    output wire lowerMode
);

    reg lower_reg;

    // Set dominates clear so a zero detect is never lost
    always @(posedge clock) begin
        if (srst) begin
            lower_reg <= 1'b0;
        end else if (setLower) begin
            lower_reg <= 1'b1;
        end else if (clearPulse) begin
            lower_reg <= 1'b0;
        end
    end

    assign lowerMode = lower_reg;

endmodule // dmdc_sel_latch
`default_nettype wire

// ==== hw/dmdc_divider.v ====
/*
 Dual modulus divider control: main and swallow down-counters driven
 by the prescaler output, modulus select to the prescaler, divided out.
 Assumes the clock is the prescaler output and that programmed values
 are static BCD digits; srst is synchronous to that clock.
*/
// Notes on behaviour
// - Upper modulus for swallow count cycles, then lower for main minus swallow.
// - Each prescaler cycle but the reload decrements main, and swallow while nonzero, by one.
// - Swallow counter holds at zero until the main count completes.
// - Select requests upper modulus while swallow nonzero, lower once zero.
// - Swallow terminal zero detect drives the modulus select change.
// - A modulus change only takes effect on the following prescaler cycle.
// - Zero detect sets latch; next edge after terminal count clears it.
// - On main terminal count output goes low and counters load.
// - Next edge returns output high and releases the preset.
// - Main count of 2 arms early decode; terminal transition next edge.
// - After reload start in upper mode unless swallow is zero; first edge decrements counters.
// - Ratio is 100 high digit plus 10 low digit plus swallow count.
// - Main 04 with swallow 3 divides by 43.
// - Swallow counter stages do not exceed main counter stages.
// - Ratio is main times base plus step times swallow count.
`timescale 1ns/1ns
`default_nettype none
`include "dmdc_regs.vh"

module dmdc_divider (
    // Clock (prescaler output) and reset
    input  wire                     clock,
    input  wire                     srst,
    // Programmed main count digits
    input  wire [`DMDC_DIGIT_W-1:0] mainCountHighDigit,
    input  wire [`DMDC_DIGIT_W-1:0] mainCountLowDigit,
    // Programmed swallow count digits
    input  wire [`DMDC_DIGIT_W-1:0] swallowHighDigit,
    input  wire [`DMDC_DIGIT_W-1:0] swallowLowDigit,
    // To the prescaler and output
    output wire                     modulusSelectIn,
    output wire                     divOut,
    output wire                     earlyArmed
);

    wire [`DMDC_DIGIT_W-1:0] mainHigh;
    wire [`DMDC_DIGIT_W-1:0] mainLow;
    wire [`DMDC_DIGIT_W-1:0] swalHigh;
    wire [`DMDC_DIGIT_W-1:0] swalLow;
    wire                     swalZero;
    wire                     swalLast;
    wire                     progSwalZero;
    wire                     setLower;
    wire                     lowerMode;
    wire                     loadNow;
    wire                     early_next;
    wire                     terminal;
    reg                      divOut_reg;
    reg                      early_reg;

    // Binary value of two BCD digits
    function [`DMDC_CNT_W-1:0] bcdValue;
        input [`DMDC_DIGIT_W-1:0] hi;
        input [`DMDC_DIGIT_W-1:0] lo;
        begin
            bcdValue = ({4'h0, hi} << 3) + ({4'h0, hi} << 1) + {4'h0, lo};
        end
    endfunction

    // Preset while output low or under reset
    assign loadNow = srst || !divOut_reg;

    // Early decode stage is armed for exactly the cycle in which main holds 2
    assign early_next = loadNow ?
        (bcdValue(mainCountHighDigit, mainCountLowDigit) == `DMDC_EARLY_VALUE) :
        (bcdValue(mainHigh, mainLow) == `DMDC_EARLY_VALUE + 8'h01);
    // Armed stage ends the period on the next edge, so the period is the main count
    assign terminal   = early_reg && divOut_reg;

    // The coming cycle is the first with the swallow count at zero, or a later one
    assign swalLast     = swalZero || (bcdValue(swalHigh, swalLow) == 8'h01);
    assign progSwalZero = (swallowHighDigit == 4'h0) && (swallowLowDigit == 4'h0);
    // On reload the latch follows the programmed swallow count, else it sets on zero
    assign setLower     = loadNow ? progSwalZero : swalLast;

    // Main counter, decremented every prescaler cycle but the reload
    dmdc_bcd_stage mainCounter (
        .clock     (clock),
        .load      (loadNow),
        .dec       (1'b1),
        .loadHigh  (mainCountHighDigit),
        .loadLow   (mainCountLowDigit),
        .countHigh (mainHigh),
        .countLow  (mainLow),
        .isZero    ()
    );

    // Swallow counter, holds at zero once reached
    dmdc_bcd_stage swallowCounter (
        .clock     (clock),
        .load      (loadNow),
        .dec       (1'b1),
        .loadHigh  (swallowHighDigit),
        .loadLow   (swallowLowDigit),
        .countHigh (swalHigh),
        .countLow  (swalLow),
        .isZero    (swalZero)
    );

    // Latch set by swallow zero detect, cleared by the reload edge; set wins
    dmdc_sel_latch selLatch (
        .clock      (clock),
        .srst       (srst),
        .setLower   (setLower),
        .clearPulse (!divOut_reg),
        .lowerMode  (lowerMode)
    );

    // Divided output and early decode stage
    always @(posedge clock) begin
        early_reg <= early_next;
        if (srst) begin
            divOut_reg <= 1'b1;
        end else if (terminal) begin
            divOut_reg <= 1'b0;
        end else if (!divOut_reg) begin
            divOut_reg <= 1'b1;
        end
    end

    // Latch is a flip-flop, so the select stands for a whole prescaler cycle
    assign modulusSelectIn = lowerMode;
    assign divOut          = divOut_reg;
    assign earlyArmed      = early_reg;

endmodule // dmdc_divider
`default_nettype wire

// ==== tb/dmdc_divider_assertions.sv ====
/* Checker on the dmdc_divider ports.
   Assumes one clock and a synchronous srst. */
`timescale 1ns/1ns
`default_nettype none
module dmdc_divider_assertions (
    // Clock and reset
    input wire logic       clock,
    input wire logic       srst,
    // Programmed digits
    input wire logic [3:0] mainCountHighDigit,
    input wire logic [3:0] mainCountLowDigit,
    input wire logic [3:0] swallowHighDigit,
    input wire logic [3:0] swallowLowDigit,
    // Outputs
    input wire logic       modulusSelectIn,
    input wire logic       divOut,
    input wire logic       earlyArmed
);
    logic [7:0] gap_reg;
    logic       seen_reg;
    wire        swNz = |{swallowHighDigit, swallowLowDigit};
    // Cycles since the last low output cycle
    always @(posedge clock) begin
        seen_reg <= !srst && (seen_reg || !divOut);
        gap_reg  <= (srst || !divOut) ? 8'h01 : gap_reg + 8'h01;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    a_low_one_cycle: assert property ($fell(divOut) |=> divOut)
        else $error("divOut low longer than one cycle");
    a_period_len: assert property (!divOut && seen_reg |-> gap_reg == 8'(mainCountHighDigit * 10 + mainCountLowDigit))
        else $error("output period differs from main count");
    a_out_reset: assert property (disable iff (1'b0) srst |=> divOut)
        else $error("divOut not high after reset");
    a_sel_reset: assert property (disable iff (1'b0) srst |=> !modulusSelectIn)
        else $error("select not upper after reset");
    a_lower_holds: assert property (modulusSelectIn && divOut |=> modulusSelectIn)
        else $error("lower modulus dropped before terminal");
    a_upper_after_low: assert property (!divOut && swNz |-> ##[1:2] !modulusSelectIn)
        else $error("select not back to upper after reload");
    a_early_then_low: assert property (earlyArmed |-> ##[0:2] !divOut)
        else $error("no terminal after early decode");
    a_low_needs_early: assert property ($fell(divOut) |-> $past(earlyArmed) || $past(earlyArmed, 2))
        else $error("terminal without early decode");
endmodule // dmdc_divider_assertions
bind dmdc_divider dmdc_divider_assertions chk (.clock(clock), .srst(srst), .mainCountHighDigit(mainCountHighDigit),
    .mainCountLowDigit(mainCountLowDigit), .swallowHighDigit(swallowHighDigit), .swallowLowDigit(swallowLowDigit),
    .modulusSelectIn(modulusSelectIn), .divOut(divOut), .earlyArmed(earlyArmed));
`default_nettype wire

// ==== tb/dmdc_prescaler_model.sv ====
/* Two-modulus prescaler model: sums input pulses per output period.
   Assumes the bench clock stands for its divided output. */
`timescale 1ns/1ns
`default_nettype none
`include "dmdc_regs.vh"
module dmdc_prescaler_model (
    // Divided clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // From the divider
    input  wire logic        modulusSelectIn,
    input  wire logic        divOut,
    // Pulses in the last full period
    output var  logic [15:0] ratio
);
    logic [15:0] acc;
    wire  [15:0] pulses = (modulusSelectIn === `DMDC_SEL_LOWER) ? 16'h000A : 16'h000B;
    // Sum moduli, closing the sum at each low output cycle
    always @(posedge clock) begin
        if (srst || divOut === 1'b0) begin
            ratio <= srst ? 16'h0000 : acc + pulses;
            acc   <= 16'h0000;
        end else begin
            acc <= acc + pulses;
        end
    end
endmodule // dmdc_prescaler_model
`default_nettype wire

// ==== tb/tb_dmdc_divider.sv ====
/* Testbench for dmdc_divider with a prescaler model.
   Assumes the clock stands for the prescaler output. */
`timescale 1ns/1ns
`default_nettype none
module tb_dmdc_divider;
    logic        clock;
    logic        srst;
    logic [3:0]  mHi, mLo, sHi, sLo;
    wire         sel, divOut, early;
    wire  [15:0] ratio;
    int          fails, n_checks;
    dmdc_divider dut (.clock(clock), .srst(srst), .mainCountHighDigit(mHi), .mainCountLowDigit(mLo),
        .swallowHighDigit(sHi), .swallowLowDigit(sLo), .modulusSelectIn(sel), .divOut(divOut), .earlyArmed(early));
    dmdc_prescaler_model model (.clock(clock), .srst(srst), .modulusSelectIn(sel), .divOut(divOut), .ratio(ratio));
    // Clock at 10 MHz
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic print_verdict;
        if (fails == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Bounded wait for an output level
    task automatic wait_out(input logic lvl);
        int n;
        n = 0;
        while (divOut !== lvl) begin
            @(negedge clock);
            n++;
            if (n > 200) begin
                fails++;
                print_verdict();
            end
        end
    endtask
    // Two-cycle reset with new digits
    task automatic do_reset(input logic [15:0] d);
        @(negedge clock);
        {mHi, mLo, sHi, sLo} = d;
        srst = 1'b1;
        repeat (2) @(negedge clock);
    endtask
    // Reset state of the outputs
    task automatic test_reset;
        do_reset(16'h0403);
        check({15'h0, divOut}, 16'h0001);
        check({15'h0, sel}, 16'h0000);
        srst = 1'b0;
    endtask
    // Division ratio over the second full period of each setting
    task automatic test_ratios;
        logic [15:0] tbl [7] = '{16'h0403, 16'h0402, 16'h0404, 16'h1205, 16'h0300, 16'h9999, 16'h2009};
        foreach (tbl[i]) begin
            do_reset(tbl[i]);
            srst = 1'b0;
            wait_out(1'b0);
            wait_out(1'b1);
            wait_out(1'b0);
            wait_out(1'b1);
            check(ratio, 16'(100 * tbl[i][15:12] + 10 * tbl[i][11:8] + 10 * tbl[i][7:4] + tbl[i][3:0]));
            if (i == 0) check(ratio, 16'h002B);
        end
    endtask
    // Main sequence
    initial begin
        {srst, mHi, mLo, sHi, sLo} = 17'h10403;
        fails = 0;
        n_checks = 0;
        test_reset();
        test_ratios();
        print_verdict();
    end
endmodule // tb_dmdc_divider
`default_nettype wire
